//--- src/proximity_ui_supervisor.sv
/*
 * Supervisory and signal processing logic of a two-channel proximity
 * controller: resets, reference tracking, movement, oversampling,
 * standalone outputs, tuning indication and watchdog.
 * Assumes a serial front end that reports byte and window events as
 * one-cycle pulses, and raw sample strobes from the converter.
 */
`timescale 1ns/1ps
module proximity_ui_supervisor #(
	parameter int WDOG_CYCLES = prox_sup_pkg::WDOG_CYC,
	parameter int DBG_CYCLES  = prox_sup_pkg::DBG_WIN_CYC,
	parameter int TUNE_CYCLES = prox_sup_pkg::TUNE_CYC,
	parameter int MS_CYCLES   = prox_sup_pkg::MS_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        clk_en,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        ready_reset_line_i,
	output logic             ready_reset_line_o,
	output logic             ready_reset_line_oe,
	input  wire logic        mode_select_input,
	output logic             data_or_touch_output,
	output logic             clock_or_touch_output_o,
	output logic             clock_or_touch_output_oe,
	input  wire logic        pad0_valid,
	input  wire logic [15:0] pad0_counts,
	input  wire logic        pad1_valid,
	input  wire logic [15:0] pad1_counts,
	input  wire logic        serial_byte,
	input  wire logic        serial_start,
	input  wire logic        serial_end,
	input  wire logic        window_req,
	input  wire logic        tune_req,
	input  wire logic        debug_exit,
	output logic             comm_window
);
	import prox_sup_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		sup_state_e        st;
		logic [TMR_W-1:0]  phase_tmr;
		logic [TMR_W-1:0]  wdog;
		logic              reset_flag;
		logic              debug_used;
		logic              in_xfer;
		logic              win;
		logic [31:0]       ctrl;
		logic [7:0]        ref_mul;
		logic [7:0]        ref_div;
		logic [7:0]        mbeta;
		logic [15:0]       mthr;
		logic [3:0]        mdeb;
		logic [15:0]       touch_thr;
		logic [15:0]       tout_ms;
		logic [1:0][21:0]  acc;
		logic [1:0][5:0]   ovs;
		logic [1:0][15:0]  cnt;
		logic [1:0][23:0]  filt;
		logic [1:0][15:0]  long_term_average;
		logic [15:0]       snap;
		logic [15:0]       adj;
		logic [1:0][3:0]   mdcnt;
		logic [1:0]        motion;
		logic              mevt;
		logic [1:0]        touch;
		logic [1:0][TMR_W-1:0] ttmr;
		logic              aw_got;
		logic              w_got;
		logic [7:0]        awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic              out_a;
		logic              out_b;
		logic              rdy_oe;
	} state_s;

	state_s q, d;

	// Absolute difference helper, used by movement and touch checks
	function automatic logic [15:0] absdiff(input logic [15:0] a,
		input logic [15:0] b);
		absdiff = (a > b) ? a - b : b - a;
	endfunction

	// Merge strobed bytes into a 32-bit register
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	logic [1:0]       raw_valid;
	logic [1:0][15:0] raw_cnt;
	logic             map_swap;
	assign map_swap  = q.ctrl[CTRL_MAP_BIT];
	// Pads are routed to channels by the mapping bit
	assign raw_valid = map_swap ? {pad0_valid, pad1_valid}
		: {pad1_valid, pad0_valid};
	assign raw_cnt   = map_swap ? {pad0_counts, pad1_counts}
		: {pad1_counts, pad0_counts};

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic        line_reset;
		logic        any_reset;
		logic        wr_fire;
		logic        kick;
		logic [31:0] wv;
		logic [5:0]  boost;
		logic        standalone;
		logic        tout_on;
		logic [TMR_W-1:0] tout_cyc;
		logic signed [33:0] delta;
		logic signed [33:0] corr;
		logic [15:0] mv;
		logic [23:0] beta_term;
		line_reset = 1'b0;
		any_reset  = 1'b0;
		wr_fire    = 1'b0;
		kick       = 1'b0;
		wv         = '0;
		delta      = '0;
		corr       = '0;
		mv         = '0;
		beta_term  = '0;
		d = q;
		boost      = (q.ctrl[CTRL_BOOST_LO +: BOOST_W] == 6'h00)
			? BOOST_RST : q.ctrl[CTRL_BOOST_LO +: BOOST_W];
		if (boost > BOOST_MAX) begin
			boost = BOOST_MAX;
		end
		standalone = q.ctrl[CTRL_IF_LO +: CTRL_IF_W] == IF_STANDALONE
			&& q.st != ST_DEBUG;
		tout_on    = !(standalone && mode_select_input);
		tout_cyc   = TMR_W'(q.tout_ms) * TMR_W'(MS_CYCLES);

		// AXI write channel capture, either order
		if (s_axi_awvalid && !q.aw_got) begin
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q.w_got) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (q.aw_got && q.w_got && !q.bvalid) begin
			wr_fire  = 1'b1;
			d.bvalid = 1'b1;
			d.aw_got = 1'b0;
			d.w_got  = 1'b0;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end

		// Register writes
		if (wr_fire) begin
			unique case (q.awaddr)
				CTRL_OFS: begin
					wv = merge(q.ctrl, q.wdata, q.wstrb);
					if (wv[CTRL_ACK_BIT]) begin
						d.reset_flag = 1'b0;
					end
					// Debug entry only once until a line reset or aresetn, inside the startup window
					if (q.st == ST_DBGWIN && !q.debug_used
						&& q.wstrb[0] && q.wdata[7:0] == DEBUG_CODE) begin
						d.st = ST_DEBUG;
						d.debug_used = 1'b1;
					end
					wv[CTRL_ACK_BIT]  = 1'b0;
					wv[CTRL_SOFT_BIT] = q.wstrb[0] && q.wdata[CTRL_SOFT_BIT];
					d.ctrl = wv;
				end
				REFSCL_OFS: begin
					wv = merge({16'h0000, q.ref_div, q.ref_mul},
						q.wdata, q.wstrb);
					d.ref_mul = wv[7:0];
					d.ref_div = (wv[15:8] == 8'h00) ? REF_DIV_RST : wv[15:8];
				end
				MOVE_OFS: begin
					wv = merge({q.mdeb, 4'h0, q.mbeta, q.mthr},
						q.wdata, q.wstrb);
					d.mthr  = wv[15:0];
					d.mbeta = wv[23:16];
					d.mdeb  = wv[31:28];
				end
				TOUT_OFS: begin
					wv = merge({q.touch_thr, q.tout_ms}, q.wdata, q.wstrb);
					d.tout_ms   = wv[15:0];
					d.touch_thr = wv[31:16];
				end
				default: begin
				end
			endcase
		end

		// AXI read channel; unmapped reads answer SLVERR
		if (s_axi_arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rresp  = 2'b00;
			unique case (s_axi_araddr)
				CTRL_OFS:   d.rdata = q.ctrl;
				STATUS_OFS: d.rdata = {23'h0, q.st == ST_TUNE,
					q.st == ST_DEBUG, q.win, q.mevt, q.motion, q.touch,
					q.reset_flag};
				REFSCL_OFS: d.rdata = {16'h0000, q.ref_div, q.ref_mul};
				MOVE_OFS:   d.rdata = {q.mdeb, 4'h0, q.mbeta, q.mthr};
				TOUT_OFS:   d.rdata = {q.touch_thr, q.tout_ms};
				CH0_OFS:    d.rdata = {q.long_term_average[0], q.cnt[0]};
				CH1_OFS:    d.rdata = {q.long_term_average[1], q.cnt[1]};
				ADJ_OFS:    d.rdata = {16'h0000, q.adj};
				SNAP_OFS:   d.rdata = {16'h0000, q.snap};
				default: begin
					d.rdata = '0;
					d.rresp = 2'b10;
				end
			endcase
			if (s_axi_araddr == STATUS_OFS) begin
				d.mevt = 1'b0;
			end
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end

		// Oversampling accumulate and movement filter per channel
		d.mevt = d.mevt;
		for (int c = 0; c < 2; c++) begin
			if (raw_valid[c]) begin
				d.acc[c] = q.acc[c] + 22'(raw_cnt[c]);
				d.ovs[c] = q.ovs[c] + 6'h01;
				if (q.ovs[c] + 6'h01 >= boost) begin
					d.acc[c] = '0;
					d.ovs[c] = '0;
					d.cnt[c] = 16'(q.acc[c] + 22'(raw_cnt[c]));
					// IIR: filt += (counts - filt) * beta / 256
					beta_term = 24'((32'(d.cnt[c]) * 32'(q.mbeta)));
					d.filt[c] = 24'((32'(q.filt[c]) * 32'(9'h100 - q.mbeta)
						+ 32'(beta_term) * 32'h100) >> 8);
					mv = absdiff(d.cnt[c], q.filt[c][23:8]);
					if ((mv > q.mthr) != q.motion[c]) begin
						d.mdcnt[c] = q.mdcnt[c] + 4'h1;
						if (q.mdcnt[c] >= q.mdeb) begin
							d.motion[c] = !q.motion[c];
							d.mdcnt[c]  = '0;
							d.mevt      = 1'b1;
						end
					end else begin
						d.mdcnt[c] = '0;
					end
				end
			end
		end

		// Reference correction of the sensing channel
		if (q.ctrl[CTRL_REF_BIT]) begin
			delta = 34'(q.cnt[1]) - 34'(q.snap);
			corr  = (delta * $signed(34'(q.ref_mul))) / $signed(34'(q.ref_div));
			d.adj = 16'(34'(q.cnt[0]) - corr);
		end else begin
			d.adj = q.cnt[0];
		end

		// Touch detection, timeout, reseed of long-term average
		for (int c = 0; c < 2; c++) begin
			if (q.st == ST_TUNE) begin
				d.long_term_average[c] = c == 0 ? d.adj : d.cnt[c];
				d.touch[c] = 1'b0;
			end else if (!q.touch[c]) begin
				if (absdiff(c == 0 ? q.adj : q.cnt[c], q.long_term_average[c])
					> q.touch_thr) begin
					d.touch[c] = 1'b1;
					d.ttmr[c]  = '0;
				end
			end else begin
				d.ttmr[c] = q.ttmr[c] + 1'b1;
				if (q.ctrl[CTRL_MOVE_BIT] && q.motion[c]) begin
					d.ttmr[c] = '0;
				end
				if (absdiff(c == 0 ? q.adj : q.cnt[c], q.long_term_average[c])
					<= q.touch_thr) begin
					d.touch[c] = 1'b0;
				end else if (tout_on && q.ttmr[c] >= tout_cyc) begin
					d.long_term_average[c]   = c == 0 ? q.adj : q.cnt[c];
					d.touch[c] = 1'b0;
				end
			end
		end

		// Supervisor sequence: startup tuning, debug window, run
		d.phase_tmr = q.phase_tmr + 1'b1;
		unique case (q.st)
			ST_TUNE: begin
				if (q.phase_tmr >= TMR_W'(TUNE_CYCLES - 1)) begin
					d.snap = q.cnt[1];
					d.phase_tmr = '0;
					d.st = (standalone && !q.debug_used)
						? ST_DBGWIN : ST_RUN;
				end
			end
			ST_DBGWIN: begin
				if (q.phase_tmr >= TMR_W'(DBG_CYCLES - 1)) begin
					d.st = ST_RUN;
				end
			end
			ST_RUN: begin
				if (tune_req) begin
					d.st = ST_TUNE;
					d.phase_tmr = '0;
				end
			end
			ST_DEBUG: begin
				if (debug_exit) begin
					d.st = ST_RUN;
				end
			end
		endcase

		// Communication window: startup debug, event mode, requests
		if (q.st == ST_DBGWIN || q.st == ST_DEBUG) begin
			d.win = !standalone || q.st == ST_DBGWIN;
		end else if (standalone) begin
			d.win = 1'b0;
		end else if (q.ctrl[CTRL_EVENT_BIT]) begin
			if (q.reset_flag || q.mevt || window_req) begin
				d.win = 1'b1;
			end
		end else if (window_req) begin
			d.win = 1'b1;
		end
		if (serial_start) begin
			d.in_xfer = 1'b1;
		end
		if (serial_end) begin
			d.in_xfer = 1'b0;
			if (q.st != ST_DBGWIN && q.st != ST_DEBUG) begin
				d.win = 1'b0;
			end
		end

		// Watchdog: kick per byte, free kick outside a window
		kick = serial_byte || !q.win;
		if (kick) begin
			d.wdog = TMR_W'(WDOG_CYCLES - 1);
		end else if (q.wdog != '0) begin
			d.wdog = q.wdog - 1'b1;
		end

		// Outputs: standalone touch or tuning indication
		d.out_a = standalone && ((|q.touch)
			|| (q.ctrl[CTRL_IND_BIT] && q.st == ST_TUNE));
		d.out_b = d.out_a;
		d.rdy_oe = d.win && !standalone;

		// Line, soft and watchdog resets restart everything except pending bus answers and, unless line reset, debug_used
		line_reset = !ready_reset_line_i && !q.rdy_oe
			&& !standalone && !q.win;
		any_reset = line_reset
			|| (q.ctrl[CTRL_SOFT_BIT])
			|| (!kick && q.wdog == '0);
		if (any_reset) begin
			d = '0;
			d.st         = ST_TUNE;
			d.reset_flag = 1'b1;
			d.debug_used = q.debug_used && !line_reset;
			d.wdog       = TMR_W'(WDOG_CYCLES - 1);
			d.ref_mul    = REF_MUL_RST;
			d.ref_div    = REF_DIV_RST;
			d.mbeta      = MBETA_RST;
			d.mthr       = MTHR_RST;
			d.mdeb       = MDEB_RST;
			d.touch_thr  = TOUCH_THR_RST;
			d.tout_ms    = TOUT_MS_RST;
			d.ctrl[CTRL_BOOST_LO +: BOOST_W] = BOOST_RST;
			d.bvalid     = q.bvalid && !s_axi_bready;
			d.rvalid     = q.rvalid && !s_axi_rready;
			d.rdata      = q.rdata;
			d.rresp      = q.rresp;
		end
	end

	// ----------------------------------------------------------------
	// Register stage; clock enable freezes everything, aresetn still acts
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.st <= ST_TUNE;
			q.reset_flag <= 1'b1;
			q.wdog <= TMR_W'(WDOG_CYCLES - 1);
			q.ref_mul <= REF_MUL_RST;
			q.ref_div <= REF_DIV_RST;
			q.mbeta <= MBETA_RST;
			q.mthr <= MTHR_RST;
			q.mdeb <= MDEB_RST;
			q.touch_thr <= TOUCH_THR_RST;
			q.tout_ms <= TOUT_MS_RST;
			q.ctrl[CTRL_BOOST_LO +: BOOST_W] <= BOOST_RST;
		end else if (clk_en) begin
			q <= d;
		end
	end

	// Ports straight from the state flops; s_axi_bresp, ready_reset_line_o and clock_or_touch_output_o tied to 0
	assign s_axi_awready           = !q.aw_got;
	assign s_axi_wready            = !q.w_got;
	assign s_axi_bvalid            = q.bvalid;
	assign s_axi_bresp             = 2'b00;
	assign s_axi_arready           = !q.rvalid;
	assign s_axi_rvalid            = q.rvalid;
	assign s_axi_rdata             = q.rdata;
	assign s_axi_rresp             = q.rresp;
	assign ready_reset_line_o      = 1'b0;
	assign ready_reset_line_oe     = q.rdy_oe;
	assign data_or_touch_output    = q.out_a;
	assign clock_or_touch_output_o = 1'b0;
	assign clock_or_touch_output_oe = q.out_b;
	assign comm_window             = q.win;

endmodule

//--- src/prox_sup_pkg.sv
/*
 * Constants for the proximity supervisor: register map, field layouts,
 * reset values, timing counts and state encodings.
 * Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus.
 */
package prox_sup_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS    = 8'h00;
	localparam logic [7:0] STATUS_OFS  = 8'h04;
	localparam logic [7:0] REFSCL_OFS  = 8'h08;
	localparam logic [7:0] MOVE_OFS    = 8'h0C;
	localparam logic [7:0] TOUT_OFS    = 8'h10;
	localparam logic [7:0] CH0_OFS     = 8'h14;
	localparam logic [7:0] CH1_OFS     = 8'h18;
	localparam logic [7:0] ADJ_OFS     = 8'h1C;
	localparam logic [7:0] SNAP_OFS    = 8'h20;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_ACK_BIT    = 0;
	localparam int CTRL_SOFT_BIT   = 1;
	localparam int CTRL_REF_BIT    = 2;
	localparam int CTRL_MOVE_BIT   = 3;
	localparam int CTRL_IND_BIT    = 4;
	localparam int CTRL_EVENT_BIT  = 5;
	localparam int CTRL_MAP_BIT    = 6;
	localparam int CTRL_IF_LO      = 8;
	localparam int CTRL_IF_W       = 2;
	localparam int CTRL_BOOST_LO   = 16;
	localparam int BOOST_W         = 6;
	localparam logic [1:0] IF_STREAM     = 2'h0;
	localparam logic [1:0] IF_EVENT      = 2'h1;
	localparam logic [1:0] IF_STANDALONE = 2'h2;
	localparam logic [7:0] DEBUG_CODE    = 8'hC0;
	localparam logic [7:0] END_COMM_CODE = 8'hFF;
	localparam logic [5:0] BOOST_RST     = 6'h01;
	localparam logic [5:0] BOOST_MAX     = 6'h32;

	// ----------------------------------------------------------------
	// Status register fields
	// ----------------------------------------------------------------
	localparam int ST_RESET_BIT  = 0;
	localparam int ST_TOUCH_LO   = 1;
	localparam int ST_MOTION_LO  = 3;
	localparam int ST_MEVT_BIT   = 5;
	localparam int ST_WIN_BIT    = 6;
	localparam int ST_DEBUG_BIT  = 7;
	localparam int ST_TUNE_BIT   = 8;

	// ----------------------------------------------------------------
	// Reset values and widths
	// ----------------------------------------------------------------
	localparam int CNT_W = 16;
	localparam logic [7:0] REF_MUL_RST  = 8'h01;
	localparam logic [7:0] REF_DIV_RST  = 8'h01;
	localparam logic [7:0] MBETA_RST    = 8'h80;
	localparam logic [15:0] MTHR_RST    = 16'h0010;
	localparam logic [3:0] MDEB_RST     = 4'h2;
	localparam logic [15:0] TOUCH_THR_RST = 16'h0040;
	localparam logic [15:0] TOUT_MS_RST = 16'h0064;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ       = 100_000_000;
	localparam int WDOG_MS      = 255;
	localparam int WDOG_CYC     = WDOG_MS * (CLK_HZ / 1000);
	localparam int MS_CYC       = CLK_HZ / 1000;
	localparam int DBG_WIN_US   = 208500;
	localparam int DBG_WIN_CYC  = DBG_WIN_US * (CLK_HZ / 1_000_000);
	localparam int TUNE_MS      = 220;
	localparam int TUNE_CYC     = TUNE_MS * MS_CYC;
	localparam int TMR_W        = 32;

	// ----------------------------------------------------------------
	// Supervisor states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_TUNE    = 4'b0001,
		ST_DBGWIN  = 4'b0010,
		ST_RUN     = 4'b0100,
		ST_DEBUG   = 4'b1000
	} sup_state_e;

endpackage

//--- test/prox_sup_monitor.sv
/* Port checker for the proximity supervisor.
 * Assumes it is bound onto proximity_ui_supervisor, one clock. */
`timescale 1ns/1ps
module prox_sup_monitor #(
	parameter int WDOG_CYCLES = 50
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	input  wire logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        ready_reset_line_o,
	input  wire logic        ready_reset_line_oe,
	input  wire logic        data_or_touch_output,
	input  wire logic        clock_or_touch_output_o,
	input  wire logic        clock_or_touch_output_oe,
	input  wire logic        serial_byte,
	input  wire logic        comm_window
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Cycles of open window without a byte; bounds the watchdog
	logic [15:0] idle_q;
	logic [15:0] idle_d;
	always_comb idle_d = (comm_window && !serial_byte) ? idle_q + 16'h1 : 16'h0;
	always_ff @(posedge aclk) idle_q <= aresetn ? idle_d : 16'h0;

	sequence aw_w_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence b_answer;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence

	AST_B_LATENCY: assert property (aw_w_taken |=> b_answer)
		else $error("write answer late or early");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	AST_B_OKAY: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
		else $error("write answer not okay");
	AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer not held");
	AST_LINE_LOW: assert property (ready_reset_line_oe |-> !ready_reset_line_o)
		else $error("line driven high");
	AST_WIN_OE: assert property ($rose(ready_reset_line_oe) |-> comm_window)
		else $error("line pulled without window");
	AST_OUTB_OD: assert property (clock_or_touch_output_oe |-> !clock_or_touch_output_o)
		else $error("output B driven high");
	AST_OUTS_PAIR: assert property (data_or_touch_output == clock_or_touch_output_oe)
		else $error("outputs A and B disagree");
	AST_WDOG: assert property (idle_q <= 16'(WDOG_CYCLES + 8))
		else $error("watchdog did not expire");
endmodule

bind proximity_ui_supervisor prox_sup_monitor #(
	.WDOG_CYCLES(WDOG_CYCLES)
) u_prox_sup_monitor (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.ready_reset_line_o(ready_reset_line_o),
	.ready_reset_line_oe(ready_reset_line_oe),
	.data_or_touch_output(data_or_touch_output),
	.clock_or_touch_output_o(clock_or_touch_output_o),
	.clock_or_touch_output_oe(clock_or_touch_output_oe),
	.serial_byte(serial_byte),
	.comm_window(comm_window)
);

//--- test/host_serial_model.sv
/* Host serial master model: window, start, byte and end pulses,
 * and the pulled-up shared ready/reset line.
 * Assumes the device pulls the line only through its enable. */
`timescale 1ns/1ps
module host_serial_model (
	input  wire logic aclk,
	input  wire logic line_oe,
	input  wire logic line_o,
	output logic      line_i,
	output logic      window_req,
	output logic      serial_start,
	output logic      serial_byte,
	output logic      serial_end
);
	logic host_low;

	// Pull-up wins unless either party pulls low
	assign line_i = !(host_low || (line_oe && !line_o));

	initial begin
		host_low = 1'b0;
		{window_req, serial_start, serial_byte, serial_end} = 4'h0;
	end

	// One-cycle event, order window/start/byte/end
	task automatic pulse(input logic [3:0] m);
		@(posedge aclk);
		{window_req, serial_start, serial_byte, serial_end} <= m;
		@(posedge aclk);
		{window_req, serial_start, serial_byte, serial_end} <= 4'h0;
	endtask

	// Always finish what was started; stop or end code
	task automatic close();
		pulse(4'h1);
	endtask

	// Host holds the line low for n cycles
	task automatic pull(input int n);
		@(posedge aclk);
		host_low <= 1'b1;
		repeat (n) @(posedge aclk);
		host_low <= 1'b0;
	endtask
endmodule

//--- test/proximity_ui_supervisor_tb.sv
/* Self-checking bench for the proximity supervisor.
 * Assumes shortened timing parameters and the host model. */
`timescale 1ns/1ps
module proximity_ui_supervisor_tb;
	import prox_sup_pkg::*;
	localparam int WDOG = 50;
	localparam int TUNE = 30;
	logic        aclk, aresetn, clk_en, mode_sel, tune_req, dbg_exit;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, pad0_v, pad1_v;
	logic        line_i, line_o, line_oe, out_a, out_b_o, out_b_oe;
	logic        win_req, s_start, s_byte, s_end, comm_window;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd_data;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rd_resp;
	logic [15:0] pad0_c, pad1_c;
	int          num_errors, checked, cycles;

	proximity_ui_supervisor #(.WDOG_CYCLES(WDOG), .DBG_CYCLES(40),
		.TUNE_CYCLES(TUNE), .MS_CYCLES(2)) u_proximity_ui_supervisor (
		.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ready_reset_line_i(line_i), .ready_reset_line_o(line_o),
		.ready_reset_line_oe(line_oe), .mode_select_input(mode_sel),
		.data_or_touch_output(out_a), .clock_or_touch_output_o(out_b_o),
		.clock_or_touch_output_oe(out_b_oe), .pad0_valid(pad0_v),
		.pad0_counts(pad0_c), .pad1_valid(pad1_v), .pad1_counts(pad1_c),
		.serial_byte(s_byte), .serial_start(s_start), .serial_end(s_end),
		.window_req(win_req), .tune_req(tune_req), .debug_exit(dbg_exit),
		.comm_window(comm_window));

	host_serial_model u_host_serial_model (.aclk(aclk), .line_oe(line_oe),
		.line_o(line_o), .line_i(line_i), .window_req(win_req),
		.serial_start(s_start), .serial_byte(s_byte), .serial_end(s_end));

	// ----------------------------------------------------------------
	// Clock, hang guard and shared tasks
	// ----------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Ceiling well above the roughly 750 cycles the tests need
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		{awvalid, wvalid, bready} <= 3'h7;
		awaddr <= a;
		wdata <= d;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awready && !aw_ok) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !w_ok) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rd_data = rdata;
		rd_resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic flag(input logic e);
		rd(STATUS_OFS);
		chk({31'h0, rd_data[ST_RESET_BIT]}, {31'h0, e});
	endtask

	// Acknowledge first, then let tuning finish before going on
	task automatic ack();
		wr(CTRL_OFS, 32'h1 << CTRL_ACK_BIT);
		repeat (100) @(posedge aclk);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_ack();
		flag(1'b1);
		ack();
		flag(1'b0);
		$display("t_ack done");
	endtask

	task automatic t_soft();
		wr(REFSCL_OFS, 32'h0305);
		rd(REFSCL_OFS);
		chk(rd_data, 32'h0305);
		wr(CTRL_OFS, 32'h1 << CTRL_SOFT_BIT);
		rd(REFSCL_OFS);
		chk(rd_data, {16'h0, REF_DIV_RST, REF_MUL_RST});
		flag(1'b1);
		ack();
		$display("t_soft done");
	endtask

	task automatic t_line();
		u_host_serial_model.pulse(4'h8);
		repeat (3) @(posedge aclk);
		chk({31'h0, comm_window}, 32'h1);
		chk({31'h0, line_oe}, 32'h1);
		u_host_serial_model.pull(4);
		flag(1'b0);
		u_host_serial_model.close();
		repeat (3) @(posedge aclk);
		u_host_serial_model.pull(3);
		repeat (4) @(posedge aclk);
		flag(1'b1);
		ack();
		$display("t_line done");
	endtask

	// Bytes closer than the period keep it alive; silence does not
	task automatic t_wdog();
		u_host_serial_model.pulse(4'h8);
		u_host_serial_model.pulse(4'h4);
		repeat (4) begin
			repeat (WDOG - 20) @(posedge aclk);
			u_host_serial_model.pulse(4'h2);
		end
		flag(1'b0);
		repeat (WDOG + 10) @(posedge aclk);
		flag(1'b1);
		chk({31'h0, comm_window}, 32'h0);
		ack();
		flag(1'b0);
		$display("t_wdog done");
	endtask

	task automatic t_unmapped();
		clk_en <= 1'b0;
		u_host_serial_model.pulse(4'h8);
		@(posedge aclk);
		chk({31'h0, comm_window}, 32'h0);
		clk_en <= 1'b1;
		rd(8'h40);
		chk(rd_data, 32'h0);
		chk({30'h0, rd_resp}, 32'h2);
		$display("t_unmapped done");
	endtask

	task automatic t_tune();
		wr(CTRL_OFS, (32'h1 << CTRL_IND_BIT) |
			(32'(IF_STANDALONE) << CTRL_IF_LO));
		@(posedge aclk);
		tune_req <= 1'b1;
		@(posedge aclk);
		tune_req <= 1'b0;
		repeat (3) @(posedge aclk);
		chk({31'h0, out_a}, 32'h1);
		chk({31'h0, out_b_oe}, 32'h1);
		repeat (TUNE + 10) @(posedge aclk);
		chk({31'h0, out_a}, 32'h0);
		wstrb <= 4'h1;
		wr(CTRL_OFS, 32'(DEBUG_CODE));
		rd(STATUS_OFS);
		chk({31'h0, rd_data[ST_DEBUG_BIT]}, 32'h1);
		dbg_exit <= 1'b1;
		@(posedge aclk);
		dbg_exit <= 1'b0;
		repeat (2) @(posedge aclk);
		chk({31'h0, comm_window}, 32'h0);
		$display("t_tune done");
	endtask

	task automatic finish_test();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{mode_sel, tune_req, dbg_exit, pad0_v, pad1_v} = 5'h0;
		{awaddr, araddr, wdata, pad0_c, pad1_c} = '0;
		{num_errors, checked, cycles} = '0;
		wstrb = 4'hF;
		clk_en = 1'b1;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_ack();
		t_soft();
		t_line();
		t_wdog();
		t_unmapped();
		t_tune();
		finish_test();
	end
endmodule
